// ===== rtl/gosm_top.sv
/*
 * Output routing for the general-purpose pins with an AXI4-Lite register
 * slave: pin two source selector, software levels, polarity, die id.
 * Assumes all inputs synchronous to i_mclk; the selectors of pin zero and
 * of the mute pin live outside and arrive as source plus register-code flag.
 */
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "gosm_defines.svh"

module gosm_top
    import gosm_pkg::*;
#(
    parameter int ADDR_W = 12,
    // arbitrary neutral identification value
    parameter logic [7:0] DIE_ID = 8'h5A
) (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic [ADDR_W-1:0] i_awaddr,
    input wire logic [2:0] i_awprot,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [ADDR_W-1:0] i_araddr,
    input wire logic [2:0] i_arprot,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    input wire gosm_flags_type i_flags,
    input wire logic i_pin0_src,
    input wire logic i_pin0_reg_sel,
    input wire logic i_mute_src,
    input wire logic i_mute_reg_sel,
    output logic o_general_pin_two,
    output logic o_general_pin_two_oe,
    output logic o_general_pin_zero,
    output logic o_mute_pin
);

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    if (ADDR_W < 9 || ADDR_W > 16) begin : g_addr_check
        $error("ADDR_W must lie between 9 and 16");
    end

    gosm_state_type q;
    gosm_state_type d;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [13:0] word_index(input logic [15:0] addr);
        word_index = addr[15:2];
    endfunction

    function automatic logic mapped(input logic [13:0] idx);
        mapped = (idx == `GOSM_IDX_PIN_DIRECTION) || (idx == `GOSM_IDX_PIN2_SRC_SEL) ||
                 (idx == `GOSM_IDX_SW_LEVELS) || (idx == `GOSM_IDX_POLARITY) ||
                 (idx == `GOSM_IDX_DIE_ID);
    endfunction

    function automatic logic [7:0] read_byte(input logic [13:0] idx, input gosm_state_type s);
        unique case (idx)
            `GOSM_IDX_PIN_DIRECTION: read_byte = s.pin_direction;
            `GOSM_IDX_PIN2_SRC_SEL: read_byte = s.pin2_output_source_select;
            `GOSM_IDX_SW_LEVELS: read_byte = s.pin_software_output_levels;
            `GOSM_IDX_POLARITY: read_byte = s.pin_output_polarity;
            `GOSM_IDX_DIE_ID: read_byte = DIE_ID;
            default: read_byte = `GOSM_RST_BYTE;
        endcase
    endfunction

    // pin two source multiplexer
    function automatic logic pin2_source(input logic [4:0] sel, input gosm_flags_type f,
                                         input logic sw_level);
        unique case (sel)
            `GOSM_SEL_OFF: pin2_source = 1'b0;
            `GOSM_SEL_DSP: pin2_source = f.dsp_pin2;
            `GOSM_SEL_REG: pin2_source = sw_level;
            `GOSM_SEL_AMUTE_BOTH: pin2_source = f.automute_l & f.automute_r;
            `GOSM_SEL_AMUTE_L: pin2_source = f.automute_l;
            `GOSM_SEL_AMUTE_R: pin2_source = f.automute_r;
            `GOSM_SEL_CLK_INVALID: pin2_source = f.clk_error | f.clk_changing | f.clk_missing;
            `GOSM_SEL_SDATA_OUT: pin2_source = f.serial_audio_data_out;
            `GOSM_SEL_ANA_MUTE_L: pin2_source = f.amute_l_n;
            `GOSM_SEL_ANA_MUTE_R: pin2_source = f.amute_r_n;
            `GOSM_SEL_PLL_LOCK: pin2_source = f.pll_lock;
            `GOSM_SEL_CP_CLK: pin2_source = f.cp_clk;
            `GOSM_SEL_OSC_DIV4: pin2_source = f.osc_clk_div4;
            `GOSM_SEL_UNDERVOLT: pin2_source = f.undervoltage_flag;
            `GOSM_SEL_OFFSET_CAL: pin2_source = f.offset_cal;
            `GOSM_SEL_CP_VALID_N: pin2_source = f.cp_valid_n;
            default: pin2_source = 1'b0;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [13:0] widx;
        logic [13:0] ridx;
        logic [7:0] wbyte;
        widx = 14'h0000;
        ridx = 14'h0000;
        wbyte = `GOSM_RST_BYTE;
        d = q;

        // write channel: address and data accepted in either order
        if (q.bvalid && i_bready) begin
            d.bvalid = 1'b0;
        end
        if (i_awvalid && q.awready) begin
            d.aw_got = 1'b1;
            d.waddr = 16'(i_awaddr);
        end
        if (i_wvalid && q.wready) begin
            d.w_got = 1'b1;
            d.wdata = i_wdata;
            d.wstrb = i_wstrb;
        end
        if (d.aw_got && d.w_got && !d.bvalid) begin
            widx = word_index(d.waddr);
            wbyte = d.wdata[7:0];
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = mapped(widx) ? `GOSM_RESP_OKAY : `GOSM_RESP_SLVERR;
            if (d.wstrb[0]) begin
                unique case (widx)
                    `GOSM_IDX_PIN_DIRECTION: d.pin_direction = wbyte;
                    `GOSM_IDX_PIN2_SRC_SEL: d.pin2_output_source_select = wbyte;
                    `GOSM_IDX_SW_LEVELS: d.pin_software_output_levels = wbyte;
                    `GOSM_IDX_POLARITY: d.pin_output_polarity = wbyte;
                    default: ;
                endcase
            end
        end
        d.awready = !d.aw_got && !d.bvalid;
        d.wready = !d.w_got && !d.bvalid;

        // read channel
        if (q.rvalid && i_rready) begin
            d.rvalid = 1'b0;
        end
        if (i_arvalid && q.arready) begin
            ridx = word_index(16'(i_araddr));
            d.rvalid = 1'b1;
            d.rdata = {24'h000000, read_byte(ridx, q)};
            d.rresp = mapped(ridx) ? `GOSM_RESP_OKAY : `GOSM_RESP_SLVERR;
        end
        d.arready = !d.rvalid;

        // pin outputs: select, then invert; pin two enable taken straight from the direction bit
        d.general_pin_two = pin2_source(q.pin2_output_source_select[`GOSM_SEL_MSB:0], i_flags,
                                        q.pin_software_output_levels[`GOSM_BIT_PIN2])
                            ^ q.pin_output_polarity[`GOSM_BIT_PIN2];
        d.general_pin_two_oe = q.pin_direction[`GOSM_BIT_PIN2_DIR];
        d.general_pin_zero = (i_pin0_reg_sel ? q.pin_software_output_levels[`GOSM_BIT_PIN0]
                              : i_pin0_src) ^ q.pin_output_polarity[`GOSM_BIT_PIN0];
        d.mute_pin = (i_mute_reg_sel ? q.pin_software_output_levels[`GOSM_BIT_MUTE]
                      : i_mute_src) ^ q.pin_output_polarity[`GOSM_BIT_MUTE];
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign o_awready = q.awready;
    assign o_wready = q.wready;
    assign o_bresp = q.bresp;
    assign o_bvalid = q.bvalid;
    assign o_arready = q.arready;
    assign o_rdata = q.rdata;
    assign o_rresp = q.rresp;
    assign o_rvalid = q.rvalid;
    assign o_general_pin_two = q.general_pin_two;
    assign o_general_pin_two_oe = q.general_pin_two_oe;
    assign o_general_pin_zero = q.general_pin_zero;
    assign o_mute_pin = q.mute_pin;

endmodule // gosm_top

`default_nettype wire

// ===== rtl/gosm_defines.svh
/*
 * Constants for the pin output select block: register indices, field
 * positions, selector codes and bus response codes.
 * Assumes inclusion by its bare name from the design files.
 */
`ifndef GOSM_DEFINES_SVH
`define GOSM_DEFINES_SVH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define GOSM_IDX_PIN_DIRECTION 14'h0008
`define GOSM_IDX_PIN2_SRC_SEL 14'h0055
`define GOSM_IDX_SW_LEVELS 14'h0056
`define GOSM_IDX_POLARITY 14'h0057
`define GOSM_IDX_DIE_ID 14'h0058

// ----------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------
`define GOSM_BIT_PIN2 5
`define GOSM_BIT_MUTE 4
`define GOSM_BIT_PIN0 3
`define GOSM_BIT_PIN2_DIR 2
`define GOSM_SEL_MSB 4
`define GOSM_RST_BYTE 8'h00

// ----------------------------------------------------------------------
// pin two selector codes
// ----------------------------------------------------------------------
`define GOSM_SEL_OFF 5'h00
`define GOSM_SEL_DSP 5'h01
`define GOSM_SEL_REG 5'h02
`define GOSM_SEL_AMUTE_BOTH 5'h03
`define GOSM_SEL_AMUTE_L 5'h04
`define GOSM_SEL_AMUTE_R 5'h05
`define GOSM_SEL_CLK_INVALID 5'h06
`define GOSM_SEL_SDATA_OUT 5'h07
`define GOSM_SEL_ANA_MUTE_L 5'h08
`define GOSM_SEL_ANA_MUTE_R 5'h09
`define GOSM_SEL_PLL_LOCK 5'h0A
`define GOSM_SEL_CP_CLK 5'h0B
`define GOSM_SEL_OSC_DIV4 5'h11
`define GOSM_SEL_UNDERVOLT 5'h14
`define GOSM_SEL_OFFSET_CAL 5'h15
`define GOSM_SEL_CP_VALID_N 5'h1B

// ----------------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------------
`define GOSM_RESP_OKAY 2'h0
`define GOSM_RESP_SLVERR 2'h2

`endif

// ===== rtl/gosm_pkg.sv
/*
 * Types for the pin output select block: routed flag bundle and the
 * complete registered state of the top module.
 * Assumes nothing of its surroundings.
 */
package gosm_pkg;

    // ------------------------------------------------------------------
    // internal signals that can be routed to pin two
    // ------------------------------------------------------------------
    typedef struct packed {
        logic dsp_pin2;
        logic automute_l;
        logic automute_r;
        logic clk_error;
        logic clk_changing;
        logic clk_missing;
        logic serial_audio_data_out;
        logic amute_l_n;
        logic amute_r_n;
        logic pll_lock;
        logic cp_clk;
        logic osc_clk_div4;
        logic undervoltage_flag;
        logic offset_cal;
        logic cp_valid_n;
    } gosm_flags_type;

    // ------------------------------------------------------------------
    // all state of the top module
    // ------------------------------------------------------------------
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic aw_got;
        logic w_got;
        logic [15:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic [7:0] pin2_output_source_select;
        logic [7:0] pin_software_output_levels;
        logic [7:0] pin_output_polarity;
        logic [7:0] pin_direction;
        logic general_pin_two;
        logic general_pin_two_oe;
        logic general_pin_zero;
        logic mute_pin;
    } gosm_state_type;

endpackage

// ===== bench/gosm_top_props.sv
/* Port checker for the pin output select block.
   Bound to gosm_top from the bench top file; sees only top ports. */
`timescale 1ns/100ps
`default_nettype none
module gosm_top_props (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_awvalid,
    input wire logic o_awready,
    input wire logic i_wvalid,
    input wire logic o_wready,
    input wire logic [1:0] o_bresp,
    input wire logic o_bvalid,
    input wire logic i_bready,
    input wire logic i_arvalid,
    input wire logic o_arready,
    input wire logic [31:0] o_rdata,
    input wire logic o_rvalid,
    input wire logic i_rready,
    input wire logic i_pin0_src,
    input wire logic i_pin0_reg_sel,
    input wire logic i_mute_src,
    input wire logic i_mute_reg_sel,
    input wire logic o_general_pin_zero,
    input wire logic o_mute_pin
);
    // ------------------------------------------------------------------
    // bus and pin relations
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);
    a_b_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("write response dropped or changed before bready");
    a_r_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read data dropped or changed before rready");
    a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
        else $error("read not answered one cycle after address");
    a_write_answer: assert property (i_awvalid && o_awready && i_wvalid && o_wready |=> o_bvalid)
        else $error("write not answered one cycle after address and data");
    a_rdata_upper: assert property (o_rvalid |-> o_rdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    a_ready_block: assert property (o_bvalid |-> !o_awready && !o_wready)
        else $error("write channel ready while response pending");
    a_pin0_follow: assert property ($past(i_rstn) && $changed(i_pin0_src) && !i_pin0_reg_sel
        && $stable(i_pin0_reg_sel) && !$rose(o_bvalid) |=> $changed(o_general_pin_zero))
        else $error("pin zero did not follow its source");
    a_mute_hold: assert property ($past(i_rstn) && $stable(i_mute_src) && $stable(i_mute_reg_sel)
        && !$rose(o_bvalid) |=> $stable(o_mute_pin))
        else $error("mute pin changed without cause");
endmodule // gosm_top_props
`default_nettype wire

// ===== bench/test_gosm_top.sv
/* Self-checking bench for the pin output select block.
   Drives the register bus and routed flags directly; checker bound below. */
`timescale 1ns/100ps
`default_nettype none
`include "gosm_defines.svh"
module test_gosm_top;
    import gosm_pkg::*;
    localparam logic [7:0] ID = 8'hA5; // arbitrary id value
    logic clk = 1'b0, rstn = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    logic p0s = 1'b0, p0r = 1'b0, ms = 1'b0, mr = 1'b0, awr, wrdy, bv, arr, rv, pin2, oe, pin0, mute;
    logic [11:0] awa = 12'h000, ara = 12'h000;
    logic [31:0] wd = 32'h00000000, rd;
    logic [1:0] br, rr;
    gosm_flags_type flg = '0;
    int fails = 0, compares = 0, n;
    logic [21:0] rows [22] = '{{5'h00, 15'h7FFF, 2'b00}, {5'h01, 15'h4000, 2'b10}, {5'h02, 15'h7FFF, 2'b00},
        {5'h03, 15'h2000, 2'b00}, {5'h03, 15'h3000, 2'b10}, {5'h04, 15'h2000, 2'b10}, {5'h05, 15'h1000, 2'b10},
        {5'h06, 15'h0800, 2'b11}, {5'h06, 15'h0400, 2'b11}, {5'h06, 15'h0200, 2'b11}, {5'h07, 15'h0100, 2'b10},
        {5'h08, 15'h0080, 2'b10}, {5'h09, 15'h0040, 2'b10}, {5'h0A, 15'h0020, 2'b10}, {5'h0B, 15'h0010, 2'b10},
        {5'h11, 15'h0008, 2'b10}, {5'h14, 15'h0004, 2'b10}, {5'h15, 15'h0002, 2'b10}, {5'h1B, 15'h0001, 2'b10},
        {5'h0C, 15'h7FFF, 2'b00}, {5'h1F, 15'h7FFF, 2'b00}, {5'h10, 15'h7FFF, 2'b00}};
    always #4 clk = ~clk;
    gosm_top #(.ADDR_W(12), .DIE_ID(ID)) gosm_top_i (.i_mclk(clk), .i_rstn(rstn), .i_awaddr(awa),
        .i_awprot(3'h0), .i_awvalid(awv), .o_awready(awr), .i_wdata(wd), .i_wstrb(4'hF), .i_wvalid(wv),
        .o_wready(wrdy), .o_bresp(br), .o_bvalid(bv), .i_bready(bry), .i_araddr(ara), .i_arprot(3'h0),
        .i_arvalid(arv), .o_arready(arr), .o_rdata(rd), .o_rresp(rr), .o_rvalid(rv), .i_rready(rry),
        .i_flags(flg), .i_pin0_src(p0s), .i_pin0_reg_sel(p0r), .i_mute_src(ms), .i_mute_reg_sel(mr),
        .o_general_pin_two(pin2), .o_general_pin_two_oe(oe), .o_general_pin_zero(pin0), .o_mute_pin(mute));
    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic results;
        if (fails == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic quit_if(input int k);
        if (k >= 50) begin
            fails++;
            results();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
        @(posedge clk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
            if (bv) break;
        end
        quit_if(n);
        bry <= 1'b0;
        chk("bresp", {30'h0, e}, {30'h0, br});
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
            if (rv) break;
        end
        quit_if(n);
        rry <= 1'b0;
        chk("rdata", e, rd);
        chk("rresp", {30'h0, er}, {30'h0, rr});
    endtask
    task automatic pins(input logic [2:0] e);
        repeat (2) @(posedge clk);
        chk("pins two zero mute", {29'h0, e}, {29'h0, pin2, pin0, mute});
    endtask
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        pins(3'b000);
        chk("oe", 32'h0, {31'h0, oe});
        for (int i = 0; i < 22; i++) begin
            wr(12'h154, {27'h0, rows[i][21:17]}, `GOSM_RESP_OKAY);
            for (int k = 0; k < 2; k++) begin
                @(posedge clk);
                flg <= gosm_flags_type'(k[0] ? ~rows[i][16:2] : rows[i][16:2]);
                p0s <= k[0];
                ms <= k[0];
                pins({rows[i][1 - k], k[0], k[0]});
            end
        end
        wr(12'h020, 32'h00000004, `GOSM_RESP_OKAY);
        pins(3'b011);
        chk("oe", 32'h1, {31'h0, oe});
        p0r <= 1'b1;
        mr <= 1'b1;
        wr(12'h154, 32'h00000002, `GOSM_RESP_OKAY);
        wr(12'h158, 32'h00000038, `GOSM_RESP_OKAY);
        pins(3'b111);
        wr(12'h15C, 32'h00000038, `GOSM_RESP_OKAY);
        pins(3'b000);
        wr(12'h158, 32'h00000000, `GOSM_RESP_OKAY);
        p0r <= 1'b0;
        p0s <= 1'b1;
        pins(3'b101);
        wr(12'h154, 32'h00000000, `GOSM_RESP_OKAY);
        pins(3'b101);
        rdc(12'h15C, 32'h00000038, `GOSM_RESP_OKAY);
        wr(12'h154, 32'h000000FF, `GOSM_RESP_OKAY);
        rdc(12'h154, 32'h000000FF, `GOSM_RESP_OKAY);
        rdc(12'h160, {24'h0, ID}, `GOSM_RESP_OKAY);
        wr(12'h160, 32'h00000000, `GOSM_RESP_OKAY);
        rdc(12'h160, {24'h0, ID}, `GOSM_RESP_OKAY);
        wr(12'h100, 32'h00000001, `GOSM_RESP_SLVERR);
        rdc(12'h100, 32'h00000000, `GOSM_RESP_SLVERR);
        p0s <= 1'b0;
        @(posedge clk);
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        pins(3'b000);
        rdc(12'h154, 32'h00000000, `GOSM_RESP_OKAY);
        rdc(12'h158, 32'h00000000, `GOSM_RESP_OKAY);
        rdc(12'h15C, 32'h00000000, `GOSM_RESP_OKAY);
        results();
    end
endmodule // test_gosm_top
bind gosm_top gosm_top_props gosm_top_props_i (.*);
`default_nettype wire
